// ===== shared/ide_cfg_pkg.sv
// constants for the ide channel config bank
// assumes config cycles and i/o requests arrive on the pci clock
package ide_cfg_pkg;
   localparam logic [7:0] OFS_CTRL_BASE = 8'h14;
   localparam logic [7:0] OFS_ZERO_A = 8'h18;
   localparam logic [7:0] OFS_ZERO_A2 = 8'h1C;
   localparam logic [7:0] OFS_BM_BASE = 8'h20;
   localparam logic [7:0] OFS_INT_LINE = 8'h3C;
   localparam logic [7:0] OFS_INT_PIN = 8'h3D;
   localparam logic [7:0] OFS_CHAN_CTRL = 8'h40;
   localparam logic [7:0] OFS_ZERO_B = 8'h44;
   localparam logic [7:0] OFS_SETUP = 8'h48;
   localparam logic [31:0] CBASE_FIXED = 32'h00000001;
   localparam logic [31:0] BBASE_FIXED = 32'h00000001;
   localparam logic [7:0] INT_LINE_RST = 8'h14;
   localparam logic [7:0] INT_PIN_VAL = 8'h01;
   localparam int CBASE_LO = 2;
   localparam int BBASE_LO = 4;
   localparam int BIT_RETRY = 13;
   localparam int BIT_PF_SLAVE = 10;
   localparam int BIT_POST4 = 9;
   localparam int BIT_PF_MASTER = 8;
   localparam int POST_LEN_LO = 4;
   localparam int PF_LEN_LO = 0;
   localparam int SU_SLAVE_LO = 4;
   localparam int SU_MASTER_LO = 0;
   localparam logic [3:0] SU_RST = 4'h3;
   localparam logic [2:0] DEPTH_ONE = 3'h1;
   localparam logic [2:0] DEPTH_FOUR = 3'h4;
   localparam logic [4:0] RETRY_CLOCKS = 5'h10;
   localparam logic [3:0] STROBE_CLOCKS = 4'h4;
   typedef enum logic [1:0] {
      IO_IDLE = 2'b00,
      IO_SETUP = 2'b01,
      IO_STROBE = 2'b10
   } io_state_t;
endpackage

// ===== src/ide_setup_strobe.sv
// address set-up then drive strobe sequencer
// assumes a start pulse only while idle
`timescale 1ns/1ps
`default_nettype none
module ide_setup_strobe #(
   parameter logic [3:0] STROBE_LEN = ide_cfg_pkg::STROBE_CLOCKS
) (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic i_write,
   input wire logic [3:0] i_setup,
   input wire logic i_abort,
   output logic o_addr_valid,
   output logic o_drive_read_strobe,
   output logic o_drive_write_strobe,
   output logic o_done
);
   import ide_cfg_pkg::*;
   typedef struct packed {
      io_state_t st;
      logic [3:0] cnt;
      logic wr;
      logic av;
      logic rd_s;
      logic wr_s;
      logic done;
   } ss_t;
   ss_t s_reg, s_next;
   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      unique case (s_reg.st)
         IO_IDLE: begin
            if (i_start) begin
               s_next.st = IO_SETUP;
               s_next.cnt = i_setup;
               s_next.wr = i_write;
               s_next.av = 1'b1;
            end
         end
         IO_SETUP: begin
            if (s_reg.cnt == 4'h0) begin
               s_next.st = IO_STROBE;
               s_next.cnt = STROBE_LEN - 4'h1;
               s_next.rd_s = !s_reg.wr;
               s_next.wr_s = s_reg.wr;
            end else begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end
         end
         IO_STROBE: begin
            if (s_reg.cnt == 4'h0) begin
               s_next = '0;
               s_next.done = 1'b1;
            end else begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end
         end
         default: s_next = '0;
      endcase
      if (i_abort) begin
         s_next = '0;
      end
   end
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         s_reg <= '0;
      end else if (i_ce) begin
         s_reg <= s_next;
      end
   end
   assign o_addr_valid = s_reg.av;
   assign o_drive_read_strobe = s_reg.rd_s;
   assign o_drive_write_strobe = s_reg.wr_s;
   assign o_done = s_reg.done;
   // helper: cycles of address valid before strobe
   logic [4:0] h_av;
   logic [3:0] h_su;
   always_ff @(posedge i_mclk) begin
      if (i_srst || !s_reg.av) begin
         h_av <= 5'h00;
      end else if (i_ce && s_reg.st == IO_SETUP) begin
         h_av <= h_av + 5'h01;
      end
      if (i_ce && i_start && s_reg.st == IO_IDLE) begin
         h_su <= i_setup;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   a_setup_before_strobe: assert property (
      $rose(o_drive_read_strobe | o_drive_write_strobe) |-> h_av == {1'b0, h_su} + 5'h01)
      else $error("strobe rose before address set-up elapsed");
endmodule
`default_nettype wire

// ===== src/ide_retry_watch.sv
// watchdog that retries slow i/o accesses
// assumes i_busy stays high from start until completion
`timescale 1ns/1ps
`default_nettype none
module ide_retry_watch #(
   parameter logic [4:0] LIMIT = ide_cfg_pkg::RETRY_CLOCKS
) (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_busy,
   input wire logic i_enable,
   output logic o_retry
);
   import ide_cfg_pkg::*;
   typedef struct packed {
      logic [4:0] cnt;
      logic retry;
   } rw_t;
   rw_t r_reg, r_next;
   always_comb begin
      r_next = r_reg;
      r_next.retry = 1'b0;
      if (!i_busy || r_reg.retry) begin
         r_next.cnt = 5'h00;
      end else if (r_reg.cnt == LIMIT - 5'h01) begin
         r_next.retry = i_enable;
         r_next.cnt = 5'h00;
      end else begin
         r_next.cnt = r_reg.cnt + 5'h01;
      end
   end
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         r_reg <= '0;
      end else if (i_ce) begin
         r_reg <= r_next;
      end
   end
   assign o_retry = r_reg.retry;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   a_retry_gated: assert property (
      o_retry |-> $past(i_enable))
      else $error("retry issued while retry disabled");
   c_retry_seen: cover property (o_retry);
endmodule
`default_nettype wire

// ===== src/ide_channel_config_regs.sv
// config register bank and pio timing for one ide channel
// assumes config and i/o requests come from logic on i_mclk
`timescale 1ns/1ps
`default_nettype none
module ide_channel_config_regs #(
   parameter logic [3:0] STROBE_LEN = ide_cfg_pkg::STROBE_CLOCKS,
   parameter logic [4:0] RETRY_LIMIT = ide_cfg_pkg::RETRY_CLOCKS
) (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_cfg_req,
   input wire logic i_cfg_wr,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [3:0] i_cfg_be,
   input wire logic [31:0] i_cfg_wdata,
   output logic [31:0] o_cfg_rdata,
   output logic o_cfg_ack,
   input wire logic i_io_enable,
   input wire logic i_io_req,
   input wire logic i_io_slave,
   input wire logic i_io_write,
   output logic o_io_busy,
   output logic o_io_done,
   output logic o_io_retry,
   output logic o_addr_valid,
   output logic o_drive_read_strobe,
   output logic o_drive_write_strobe,
   output logic o_prefetch_master_en,
   output logic o_prefetch_slave_en,
   output logic [2:0] o_post_depth,
   output logic [2:0] o_write_burst_len,
   output logic [2:0] o_read_burst_len
);
   import ide_cfg_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [15:CBASE_LO] cbase;
      logic [15:BBASE_LO] bbase;
      logic [7:0] iline;
      logic retry_en;
      logic pf_s;
      logic post4;
      logic pf_m;
      logic [1:0] plen;
      logic [1:0] flen;
      logic [3:0] su_s;
      logic [3:0] su_m;
      logic [31:0] rdata;
      logic ack;
      logic busy;
      logic start;
      logic wr;
      logic [3:0] su_sel;
      logic [2:0] depth;
      logic [2:0] wblen;
      logic [2:0] rblen;
   } st_t;
   st_t s_reg, s_next;

   logic sub_done;
   logic sub_retry;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = a[7:2] == ofs[7:2];
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] be);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge[8*i +: 8] = nw[8*i +: 8];
         end
      end
   endfunction

   // ****************************************
   // register views
   // ****************************************
   logic [31:0] v_cbase;
   logic [31:0] v_bbase;
   logic [31:0] v_int;
   logic [31:0] v_ctrl;
   logic [31:0] v_setup;
   always_comb begin
      v_cbase = CBASE_FIXED;
      v_cbase[15:CBASE_LO] = s_reg.cbase;
      v_bbase = BBASE_FIXED;
      v_bbase[15:BBASE_LO] = s_reg.bbase;
      v_int = {16'h0000, INT_PIN_VAL, s_reg.iline};
      v_ctrl = 32'h00000000;
      v_ctrl[BIT_RETRY] = s_reg.retry_en;
      v_ctrl[BIT_PF_SLAVE] = s_reg.pf_s;
      v_ctrl[BIT_POST4] = s_reg.post4;
      v_ctrl[BIT_PF_MASTER] = s_reg.pf_m;
      v_ctrl[POST_LEN_LO +: 2] = s_reg.plen;
      v_ctrl[PF_LEN_LO +: 2] = s_reg.flen;
      v_setup = {24'h000000, s_reg.su_s, s_reg.su_m};
   end

   // ****************************************
   // next state
   // ****************************************
   logic [31:0] m;
   always_comb begin
      s_next = s_reg;
      m = 32'h00000000;
      s_next.ack = 1'b0;
      s_next.start = 1'b0;
      if (i_cfg_req) begin
         s_next.ack = 1'b1;
         s_next.rdata = 32'h00000000;
         if (hit(i_cfg_addr, OFS_CTRL_BASE)) begin
            s_next.rdata = v_cbase;
         end
         if (hit(i_cfg_addr, OFS_BM_BASE)) begin
            s_next.rdata = v_bbase;
         end
         if (hit(i_cfg_addr, OFS_INT_LINE)) begin
            s_next.rdata = v_int;
         end
         if (hit(i_cfg_addr, OFS_CHAN_CTRL)) begin
            s_next.rdata = v_ctrl;
         end
         if (hit(i_cfg_addr, OFS_SETUP)) begin
            s_next.rdata = v_setup;
         end
      end
      if (i_cfg_req && i_cfg_wr) begin
         if (hit(i_cfg_addr, OFS_CTRL_BASE)) begin
            m = merge(v_cbase, i_cfg_wdata, i_cfg_be);
            s_next.cbase = m[15:CBASE_LO];
         end
         if (hit(i_cfg_addr, OFS_BM_BASE)) begin
            m = merge(v_bbase, i_cfg_wdata, i_cfg_be);
            s_next.bbase = m[15:BBASE_LO];
         end
         if (hit(i_cfg_addr, OFS_INT_LINE)) begin
            m = merge(v_int, i_cfg_wdata, i_cfg_be);
            s_next.iline = m[7:0];
         end
         if (hit(i_cfg_addr, OFS_CHAN_CTRL)) begin
            m = merge(v_ctrl, i_cfg_wdata, i_cfg_be);
            s_next.retry_en = m[BIT_RETRY];
            s_next.pf_s = m[BIT_PF_SLAVE];
            s_next.post4 = m[BIT_POST4];
            s_next.pf_m = m[BIT_PF_MASTER];
            s_next.plen = m[POST_LEN_LO +: 2];
            s_next.flen = m[PF_LEN_LO +: 2];
         end
         if (hit(i_cfg_addr, OFS_SETUP)) begin
            m = merge(v_setup, i_cfg_wdata, i_cfg_be);
            s_next.su_s = m[SU_SLAVE_LO +: 4];
            s_next.su_m = m[SU_MASTER_LO +: 4];
         end
      end
      s_next.depth = s_next.post4 ? DEPTH_FOUR : DEPTH_ONE;
      s_next.wblen = {1'b0, s_next.plen} + 3'h1;
      s_next.rblen = {1'b0, s_next.flen} + 3'h1;
      if (s_reg.busy && (sub_done || sub_retry)) begin
         s_next.busy = 1'b0;
      end
      if (!s_reg.busy && i_io_req && i_io_enable) begin
         s_next.busy = 1'b1;
         s_next.start = 1'b1;
         s_next.wr = i_io_write;
         s_next.su_sel = i_io_slave ? s_reg.su_s : s_reg.su_m;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         s_reg <= '0;
         s_reg.iline <= INT_LINE_RST;
         s_reg.su_s <= SU_RST;
         s_reg.su_m <= SU_RST;
         s_reg.depth <= DEPTH_ONE;
         s_reg.wblen <= 3'h1;
         s_reg.rblen <= 3'h1;
      end else if (i_ce) begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // timing engines
   // ****************************************
   ide_setup_strobe #(
      .STROBE_LEN(STROBE_LEN)
   ) u_strobe (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_start(s_reg.start),
      .i_write(s_reg.wr),
      .i_setup(s_reg.su_sel),
      .i_abort(sub_retry),
      .o_addr_valid(o_addr_valid),
      .o_drive_read_strobe(o_drive_read_strobe),
      .o_drive_write_strobe(o_drive_write_strobe),
      .o_done(sub_done)
   );

   // the watchdog sees busy from the start pulse onward
   ide_retry_watch #(
      .LIMIT(RETRY_LIMIT)
   ) u_retry (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_busy(s_reg.busy),
      .i_enable(s_reg.retry_en),
      .o_retry(sub_retry)
   );

   assign o_cfg_rdata = s_reg.rdata;
   assign o_cfg_ack = s_reg.ack;
   assign o_io_busy = s_reg.busy;
   assign o_io_done = sub_done;
   assign o_io_retry = sub_retry;
   assign o_prefetch_master_en = s_reg.pf_m;
   assign o_prefetch_slave_en = s_reg.pf_s;
   assign o_post_depth = s_reg.depth;
   assign o_write_burst_len = s_reg.wblen;
   assign o_read_burst_len = s_reg.rblen;

   // ****************************************
   // checks
   // ****************************************
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   logic rd_ok;
   logic wr_ok;
   assign rd_ok = i_ce && i_cfg_req;
   assign wr_ok = i_ce && i_cfg_req && i_cfg_wr;

   // helper: cycles the current access has been busy
   // saturates so a very long access cannot wrap back onto the deadline
   logic [5:0] h_busy;
   always_ff @(posedge i_mclk) begin
      if (i_srst || !s_reg.busy) begin
         h_busy <= 6'h00;
      end else if (i_ce && h_busy != 6'h3F) begin
         h_busy <= h_busy + 6'h01;
      end
   end

   a_cbase_fixed: assert property (
      rd_ok && hit(i_cfg_addr, OFS_CTRL_BASE) |=>
      o_cfg_rdata[1:0] == 2'b01 && o_cfg_rdata[31:16] == 16'h0000)
      else $error("control base fixed bits wrong");
   a_bbase_fixed: assert property (
      rd_ok && hit(i_cfg_addr, OFS_BM_BASE) |=>
      o_cfg_rdata[3:0] == 4'h1 && o_cfg_rdata[31:16] == 16'h0000)
      else $error("bus-master base fixed bits wrong");
   a_zero_18: assert property (
      rd_ok && (hit(i_cfg_addr, OFS_ZERO_A) || hit(i_cfg_addr, OFS_ZERO_A2))
      |=> o_cfg_rdata == 32'h00000000)
      else $error("18H-1FH not zero");
   a_int_line_rw: assert property (
      wr_ok && hit(i_cfg_addr, OFS_INT_LINE) && i_cfg_be[0] |=> s_reg.iline == $past(i_cfg_wdata[7:0]))
      else $error("interrupt line did not keep write");
   a_int_pin_ro: assert property (
      rd_ok && hit(i_cfg_addr, OFS_INT_PIN) |=> o_cfg_rdata[15:8] == INT_PIN_VAL)
      else $error("interrupt pin not 01H");
   a_zero_3e: assert property (
      rd_ok && hit(i_cfg_addr, OFS_INT_LINE) |=> o_cfg_rdata[31:16] == 16'h0000)
      else $error("3EH-3FH not zero");
   a_retry_on: assert property (
      o_io_retry |-> s_reg.retry_en && $past(s_reg.busy, 16))
      else $error("retry without enable or before 16 clocks");
   a_retry_deadline: assert property (
      h_busy == 6'h10 && $past(s_reg.retry_en) |-> o_io_retry)
      else $error("slow access not retried at 16 clocks");
   a_pf_slave: assert property (
      wr_ok && hit(i_cfg_addr, OFS_CHAN_CTRL) && i_cfg_be[1]
      |=> o_prefetch_slave_en == $past(i_cfg_wdata[BIT_PF_SLAVE]))
      else $error("slave prefetch enable wrong");
   a_pf_master: assert property (
      wr_ok && hit(i_cfg_addr, OFS_CHAN_CTRL) && i_cfg_be[1]
      |=> o_prefetch_master_en == $past(i_cfg_wdata[BIT_PF_MASTER]))
      else $error("master prefetch enable wrong");
   a_post_depth: assert property (
      wr_ok && hit(i_cfg_addr, OFS_CHAN_CTRL) && i_cfg_be[1]
      |=> o_post_depth == ($past(i_cfg_wdata[BIT_POST4]) ? 3'h4 : 3'h1))
      else $error("posted-write depth wrong");
   a_post_len: assert property (
      wr_ok && hit(i_cfg_addr, OFS_CHAN_CTRL) && i_cfg_be[0]
      |=> o_write_burst_len == {1'b0, $past(i_cfg_wdata[5:4])} + 3'h1)
      else $error("post burst length wrong");
   a_pf_len: assert property (
      wr_ok && hit(i_cfg_addr, OFS_CHAN_CTRL) && i_cfg_be[0]
      |=> o_read_burst_len == {1'b0, $past(i_cfg_wdata[1:0])} + 3'h1)
      else $error("prefetch burst length wrong");
   a_zero_44: assert property (
      rd_ok && hit(i_cfg_addr, OFS_ZERO_B) |=> o_cfg_rdata == 32'h00000000)
      else $error("44H-47H not zero");
   a_setup_select: assert property (
      s_reg.start |-> s_reg.su_sel == ($past(i_io_slave) ? $past(s_reg.su_s) : $past(s_reg.su_m)))
      else $error("wrong drive set-up chosen");
   a_io_gated: assert property (
      i_ce && !s_reg.busy && !i_io_enable |=> !s_reg.busy && !s_reg.start)
      else $error("i/o accepted while disabled");
   a_fixed_on_write: assert property (
      rd_ok && hit(i_cfg_addr, OFS_SETUP) |=> o_cfg_rdata[31:8] == 24'h000000)
      else $error("reserved setup bits took a write");
   a_reset_defaults: assert property (
      $fell(i_srst) |-> s_reg.iline == 8'h14 && s_reg.su_s == 4'h3 && s_reg.su_m == 4'h3
      && s_reg.cbase == '0 && !s_reg.retry_en)
      else $error("reset defaults wrong");

   c_cfg_write: cover property (wr_ok && hit(i_cfg_addr, OFS_CHAN_CTRL));
   c_io_read: cover property ($rose(o_drive_read_strobe));
   c_io_done: cover property (o_io_done);
   c_io_write: cover property ($rose(o_drive_write_strobe));
endmodule
`default_nettype wire

// ===== testbench/cfg_host_model.sv
// config-cycle host model driving the channel bank
// assumes the bank acks one cycle after each request, all on i_mclk
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
   input wire logic i_mclk,
   input wire logic i_cfg_ack,
   input wire logic [31:0] i_cfg_rdata,
   output logic o_cfg_req,
   output logic o_cfg_wr,
   output logic [7:0] o_cfg_addr,
   output logic [3:0] o_cfg_be,
   output logic [31:0] o_cfg_wdata
);
   initial begin
      o_cfg_req = 1'b0;
      o_cfg_wr = 1'b0;
      o_cfg_addr = 8'h00;
      o_cfg_be = 4'h0;
      o_cfg_wdata = 32'h00000000;
   end
   // drives are disks
   // prefetch may be set since no cd-rom hangs on this channel
   // ****************************************
   // one config cycle: a single-cycle request, then the ack
   // ****************************************
   task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                         output logic [31:0] rd);
      int n;
      @(posedge i_mclk);
      #1;
      o_cfg_req = 1'b1;
      o_cfg_wr = wr;
      o_cfg_addr = addr;
      o_cfg_be = 4'hF;
      o_cfg_wdata = wd;
      @(posedge i_mclk);
      #1;
      // released wr, addr and wdata lines toggle so stale values are never mistaken for live ones; be stays at all ones
      o_cfg_req = 1'b0;
      o_cfg_wr = ~wr;
      o_cfg_addr = ~addr;
      o_cfg_wdata = ~wd;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (i_cfg_ack !== 1'b1 && n < 4);
      rd = (i_cfg_ack === 1'b1) ? i_cfg_rdata : 32'hxxxxxxxx;
   endtask
endmodule
`default_nettype wire

// ===== testbench/tb_ide_channel_config_regs.sv
// self-checking bench for the ide channel config bank
// assumes the package is compiled first; strobe widened to 15 clocks, the retry limit is reached during the 0FH set-up before any strobe
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
   $display("ERROR %0t: got %h want %h", $time, a, e); end end
module tb_ide_channel_config_regs;
   import ide_cfg_pkg::*;
   logic i_mclk, i_srst, i_io_enable, i_io_req, i_io_slave, i_io_write;
   logic cfg_req, cfg_wr, cfg_ack, io_busy, io_done, io_retry, addr_valid, rd_stb, wr_stb, pf_m, pf_s;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, rd;
   logic [2:0] depth, wlen, rlen;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   logic [7:0] ofs [8] = '{8'h14, 8'h20, 8'h3C, 8'h40, 8'h48, 8'h18, 8'h1C, 8'h44};
   logic [31:0] rst_v [8] = '{32'h00000001, 32'h00000001, 32'h00000114, 32'h00000000,
                              32'h00000033, 32'h00000000, 32'h00000000, 32'h00000000};
   logic [31:0] one_v [8] = '{32'h0000FFFD, 32'h0000FFF1, 32'h000001FF, 32'h00002733,
                              32'h000000FF, 32'h00000000, 32'h00000000, 32'h00000000};
   ide_channel_config_regs #(.STROBE_LEN(4'hF), .RETRY_LIMIT(5'h10)) i_ide_channel_config_regs (
      .i_mclk(i_mclk), .i_srst(i_srst), .i_ce(1'b1), .i_cfg_req(cfg_req), .i_cfg_wr(cfg_wr),
      .i_cfg_addr(cfg_addr), .i_cfg_be(cfg_be), .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata),
      .o_cfg_ack(cfg_ack), .i_io_enable(i_io_enable), .i_io_req(i_io_req), .i_io_slave(i_io_slave),
      .i_io_write(i_io_write), .o_io_busy(io_busy), .o_io_done(io_done), .o_io_retry(io_retry),
      .o_addr_valid(addr_valid), .o_drive_read_strobe(rd_stb), .o_drive_write_strobe(wr_stb),
      .o_prefetch_master_en(pf_m), .o_prefetch_slave_en(pf_s), .o_post_depth(depth),
      .o_write_burst_len(wlen), .o_read_burst_len(rlen));
   cfg_host_model i_cfg_host_model (
      .i_mclk(i_mclk), .i_cfg_ack(cfg_ack), .i_cfg_rdata(cfg_rdata), .o_cfg_req(cfg_req),
      .o_cfg_wr(cfg_wr), .o_cfg_addr(cfg_addr), .o_cfg_be(cfg_be), .o_cfg_wdata(cfg_wdata));
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic reset_dut();
      @(posedge i_mclk);
      #1;
      i_srst = 1'b1;
      repeat (10) @(posedge i_mclk);
      #1;
      i_srst = 1'b0;
   endtask
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      i_cfg_host_model.access(1'b1, a, d, rd);
   endtask
   task automatic read_table(input logic [31:0] exp_v [8]);
      for (int i = 0; i < 8; i++) begin
         i_cfg_host_model.access(1'b0, ofs[i], 32'h00000000, rd);
         `CHK(rd, exp_v[i])
      end
   endtask
   // outputs are read one step after each edge, once the flops have settled
   task automatic wait_hi(ref logic s, input int lim, output int n);
      n = 0;
      do begin
         @(posedge i_mclk);
         #1;
         n++;
      end while (s !== 1'b1 && n < lim);
   endtask
   // one pio access; su is the expected address-to-strobe distance
   task automatic io_run(input logic slv, input logic w, input int su);
      int n;
      @(posedge i_mclk);
      #1;
      i_io_req = 1'b1;
      i_io_slave = slv;
      i_io_write = w;
      wait_hi(io_busy, 4, n);
      i_io_req = 1'b0;
      if (addr_valid !== 1'b1) wait_hi(addr_valid, 4, n);
      n = 0;
      do begin
         @(posedge i_mclk);
         #1;
         n++;
      end while (rd_stb !== 1'b1 && wr_stb !== 1'b1 && n < 40);
      `CHK(n, su)
      `CHK({wr_stb, rd_stb}, {w, ~w})
      wait_hi(io_done, 40, n);
      `CHK(io_done, 1'b1)
      @(posedge i_mclk);
      #1;
      `CHK(io_busy, 1'b0)
      @(posedge i_mclk);
   endtask
   always @(posedge i_mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         end_of_test();
      end
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      int n;
      i_srst = 1'b1;
      i_io_enable = 1'b1;
      i_io_req = 1'b0;
      i_io_slave = 1'b0;
      i_io_write = 1'b0;
      repeat (10) @(posedge i_mclk);
      #1;
      i_srst = 1'b0;
      read_table(rst_v);
      `CHK({pf_m, pf_s, depth, wlen, rlen}, {2'b00, DEPTH_ONE, 3'h1, 3'h1})
      $display("test reset values done");
      for (int i = 0; i < 8; i++) wr32(ofs[i], 32'hFFFFFFFF);
      read_table(one_v);
      `CHK({pf_m, pf_s, depth, wlen, rlen}, {2'b11, DEPTH_FOUR, 3'h4, 3'h4})
      $display("test all ones done");
      reset_dut();
      read_table(rst_v);
      $display("test second reset done");
      wr32(8'h40, 32'h00000612);
      wr32(8'h48, 32'h00000052);
      `CHK({pf_m, pf_s, depth, wlen, rlen}, {2'b01, DEPTH_FOUR, 3'h2, 3'h3})
      io_run(1'b1, 1'b1, 6);
      io_run(1'b0, 1'b0, 3);
      wr32(8'h48, 32'h0000000F);
      // long access with retry off must still complete
      io_run(1'b0, 1'b1, 16);
      $display("test pio timing done");
      wr32(8'h40, 32'h00002000);
      @(posedge i_mclk);
      #1;
      i_io_req = 1'b1;
      wait_hi(io_busy, 4, n);
      i_io_req = 1'b0;
      wait_hi(io_retry, 30, n);
      `CHK(n, 16)
      `CHK(io_retry, 1'b1)
      `CHK({wr_stb, rd_stb}, 2'b00)
      repeat (2) @(posedge i_mclk);
      #1;
      `CHK({io_busy, addr_valid}, 2'b00)
      $display("test retry done");
      i_io_enable = 1'b0;
      i_io_req = 1'b1;
      repeat (10) @(posedge i_mclk);
      #1;
      `CHK({io_busy, addr_valid}, 2'b00)
      i_io_req = 1'b0;
      $display("test io disabled done");
      end_of_test();
   end
endmodule
`default_nettype wire
